// ==== verilog/write_long_same_cdb_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none

module write_long_same_cdb_decoder
    import wls_pkg::*;
(
    input  wire  logic                 clk_sys_i,
    input  wire  logic                 reset_n_i,
    input  wire  logic                 cdb_valid_i,
    input  wire  logic [8*CDB_BYTES-1:0] cdb_i,
    input  wire  logic [15:0]          data_len_i,
    input  wire  logic                 data_valid_i,
    input  wire  logic                 protection_enabled_flag_i,
    input  wire  logic [2:0]           prot_type_i,
    input  wire  logic                 application_tag_owner_i,
    input  wire  logic [63:0]          last_lba_i,
    input  wire  logic [31:0]          first_ref_tag_i,
    input  wire  logic                 media_ready_i,
    output logic                       cdb_ready_o,
    output logic                       data_ready_o,
    output logic                       media_wr_o,
    output media_wr_s                  media_req_o,
    output logic                       cache_drop_o,
    output logic                       done_o,
    output completion_s                cpl_o
);
    import wls_pkg::*;

    state_e       state_q;
    cmd_e         cmd_q;
    logic [8*CDB_BYTES-1:0] cdb_q;
    logic [63:0]  lba_q;
    logic [63:0]  remain_q;
    logic         first_q;
    logic [15:0]  dlen_q;

    // Byte n of the CDB, byte 0 in the top lane
    function automatic logic [7:0] cb(input logic [8*CDB_BYTES-1:0] c,
                                      input int n);
        cb = c[8*(CDB_BYTES-1-n) +: 8];
    endfunction : cb

    // ******************************************************
    // Decode
    // ******************************************************
    cmd_e        cmd_d;
    logic        rsvd_bad;
    logic        opc_bad;
    logic [63:0] lba_d;
    logic [63:0] cnt_d;
    logic [15:0] xfer_len;
    logic [7:0]  cdb_b1;
    logic [7:0]  cdb_b10;
    logic        len_bad;
    logic        chk_bad;
    logic        ref_bad;
    logic        last_wr;

    // Flag bytes named, a call result cannot be bit-selected
    assign cdb_b1  = cb(cdb_q, 1);
    assign cdb_b10 = cb(cdb_q, 10);

    always_comb begin
        cmd_d    = CMD_NONE;
        rsvd_bad = 1'b0;
        opc_bad  = 1'b0;
        lba_d    = LBA_RST;
        cnt_d    = 64'h0;
        xfer_len = {cb(cdb_q, 12), cb(cdb_q, 13)};
        if (cb(cdb_q, 0) == OP_LONG16 &&
            cdb_b1[4:0] == SA_LONG16) begin
            cmd_d    = CMD_LONG16;
            lba_d    = {cb(cdb_q, 2), cb(cdb_q, 3), cb(cdb_q, 4), cb(cdb_q, 5),
                        cb(cdb_q, 6), cb(cdb_q, 7), cb(cdb_q, 8), cb(cdb_q, 9)};
            cnt_d    = 64'h1;
            rsvd_bad = cdb_b1[5] || cdb_b10 != 8'h00 ||
                       cb(cdb_q, 11) != 8'h00 || cb(cdb_q, 14) != 8'h00 ||
                       cb(cdb_q, 15) != 8'h00;
        end else if (cb(cdb_q, 0) == OP_SAME10) begin
            cmd_d    = CMD_SAME;
            lba_d    = {32'h0, cb(cdb_q, 2), cb(cdb_q, 3), cb(cdb_q, 4),
                        cb(cdb_q, 5)};
            cnt_d    = {48'h0, cb(cdb_q, 7), cb(cdb_q, 8)};
            rsvd_bad = cdb_b1[4:1] != 4'h0 || cb(cdb_q, 6) != 8'h00 ||
                       cb(cdb_q, 9) != 8'h00;
        end else if (cb(cdb_q, 0) == OP_SAME16) begin
            cmd_d    = CMD_SAME;
            lba_d    = {cb(cdb_q, 2), cb(cdb_q, 3), cb(cdb_q, 4), cb(cdb_q, 5),
                        cb(cdb_q, 6), cb(cdb_q, 7), cb(cdb_q, 8), cb(cdb_q, 9)};
            cnt_d    = {32'h0, cb(cdb_q, 10), cb(cdb_q, 11), cb(cdb_q, 12),
                        cb(cdb_q, 13)};
            rsvd_bad = cdb_b1[4:1] != 4'h0 ||
                       cb(cdb_q, 14) != 8'h00 ||
                       cb(cdb_q, 15) != 8'h00;
        end else if (cb(cdb_q, 0) == OP_VARLEN &&
                     cb(cdb_q, 7) == ADD_LEN_32 &&
                     {cb(cdb_q, 8), cb(cdb_q, 9)} == SA_SAME32) begin
            cmd_d    = CMD_SAME32;
            lba_d    = {cb(cdb_q, 12), cb(cdb_q, 13), cb(cdb_q, 14),
                        cb(cdb_q, 15), cb(cdb_q, 16), cb(cdb_q, 17),
                        cb(cdb_q, 18), cb(cdb_q, 19)};
            cnt_d    = {32'h0, cb(cdb_q, 28), cb(cdb_q, 29), cb(cdb_q, 30),
                        cb(cdb_q, 31)};
            opc_bad  = !(protection_enabled_flag_i &&
                         prot_type_i == PTYPE_TYPE2);
            rsvd_bad = cb(cdb_q, 1) != 8'h00 || cb(cdb_q, 2) != 8'h00 ||
                       cb(cdb_q, 3) != 8'h00 || cb(cdb_q, 4) != 8'h00 ||
                       cb(cdb_q, 5) != 8'h00 || cb(cdb_q, 6) != 8'h00 ||
                       cdb_b10[4:0] != 5'h0 ||
                       cb(cdb_q, 11) != 8'h00;
        end else begin
            opc_bad = 1'b1;
        end
        // Zero count means to the end of the unit
        if (cmd_d != CMD_LONG16 && cnt_d == 64'h0) begin
            cnt_d = 64'(last_lba_i - lba_d + 64'h1);
        end
    end

    // Length judged against the value taken with the CDB
    assign len_bad = cmd_d == CMD_LONG16 && xfer_len != 16'h0 &&
                     xfer_len != dlen_q;
    assign chk_bad = opc_bad || rsvd_bad || len_bad;
    // Ref tag miss ends the command after its first block
    assign ref_bad = cmd_q == CMD_SAME32 && first_q && media_ready_i &&
                     first_ref_tag_i != media_req_o.ref_tag;
    assign last_wr = media_ready_i && (remain_q == 64'h1 || ref_bad);

    // ******************************************************
    // Sequencer
    // ******************************************************
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE:  if (cdb_valid_i) state_q <= ST_CHK;
                // CDB check errors finish here, done_o pulses from the check itself
                ST_CHK:   state_q <= chk_bad ? ST_IDLE : ST_DATA;
                ST_DATA:  if (data_valid_i) state_q <= ST_WRITE;
                ST_WRITE: if (last_wr) state_q <= ST_DONE;
                ST_DONE:  state_q <= ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cdb_q    <= '0;
            cmd_q    <= CMD_NONE;
            lba_q    <= LBA_RST;
            remain_q <= 64'h0;
            first_q  <= 1'b0;
            dlen_q   <= 16'h0;
        end else if (state_q == ST_IDLE && cdb_valid_i) begin
            cdb_q  <= cdb_i;
            dlen_q <= data_len_i;
        end else if (state_q == ST_CHK) begin
            cmd_q    <= cmd_d;
            lba_q    <= lba_d;
            remain_q <= cnt_d;
            first_q  <= 1'b1;
        end else if (state_q == ST_WRITE && media_ready_i) begin
            lba_q    <= lba_q + 64'h1;
            remain_q <= remain_q - 64'h1;
            first_q  <= 1'b0;
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    logic [7:0] b1;
    logic       ato_use;
    assign b1      = (cmd_q == CMD_SAME32) ? cb(cdb_q, 10) : cb(cdb_q, 1);
    assign ato_use = application_tag_owner_i && cmd_q == CMD_SAME32;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cdb_ready_o  <= 1'b0;
            data_ready_o <= 1'b0;
            media_wr_o   <= 1'b0;
            media_req_o  <= '0;
            cache_drop_o <= 1'b0;
        end else begin
            cdb_ready_o  <= state_q == ST_IDLE && !cdb_valid_i;
            data_ready_o <= state_q == ST_CHK && !chk_bad;
            // Held until the media side accepts; one data block repeats
            media_wr_o   <= (state_q == ST_DATA && data_valid_i) ||
                            (state_q == ST_WRITE && !last_wr);
            cache_drop_o <= state_q == ST_WRITE && last_wr &&
                            cmd_q != CMD_LONG16;
            media_req_o.lba          <= (state_q == ST_WRITE && media_ready_i)
                                        ? lba_q + 64'h1 : lba_q;
            media_req_o.correction_disable_bit      <= cmd_q == CMD_LONG16 && b1[7];
            // Plain long write acts as uncorrectable unless disable is set
            media_req_o.uncor        <= cmd_q == CMD_LONG16 && !b1[7];
            media_req_o.pi_present   <= protection_enabled_flag_i;
            media_req_o.pi_ref_check <= cmd_q == CMD_SAME32 &&
                                        (state_q == ST_DATA ||
                                         (first_q && !media_ready_i));
            media_req_o.ref_tag      <= {cb(cdb_q, 20), cb(cdb_q, 21),
                                         cb(cdb_q, 22), cb(cdb_q, 23)};
            media_req_o.app_tag      <= ato_use ? {cb(cdb_q, 24),
                                         cb(cdb_q, 25)} : 16'h0;
            media_req_o.app_mask     <= ato_use ? {cb(cdb_q, 26),
                                         cb(cdb_q, 27)} : 16'h0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
            cpl_o  <= CPL_RST;
        end else begin
            done_o <= 1'b0;
            if (state_q == ST_CHK) begin
                done_o <= chk_bad;
                cpl_o  <= CPL_RST;
                if (opc_bad) begin
                    cpl_o <= '{ST_CHECK, SK_ILLEGAL, ASC_BAD_OPCODE,
                               1'b0, 32'h0};
                end else if (rsvd_bad) begin
                    cpl_o <= '{ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD,
                               1'b0, 32'h0};
                end else if (len_bad) begin
                    cpl_o <= '{ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD, 1'b1,
                               32'(signed'({1'b0, xfer_len}) -
                                   signed'({1'b0, dlen_q}))};
                end
            end else if (state_q == ST_WRITE && ref_bad) begin
                cpl_o  <= '{ST_CHECK, SK_ILLEGAL, ASC_REF_TAG,
                            1'b0, 32'h0};
            end else if (state_q == ST_DONE) begin
                done_o <= 1'b1;
            end
        end
    end

endmodule : write_long_same_cdb_decoder

`default_nettype wire

// ==== verilog/wls_pkg.sv ====
package wls_pkg;

    // ******************************************************
    // Opcodes and CDB layout
    // ******************************************************
    localparam logic [7:0]  OP_LONG16      = 8'h9f;
    localparam logic [4:0]  SA_LONG16      = 5'h11;
    localparam logic [7:0]  OP_SAME10      = 8'h41;
    localparam logic [7:0]  OP_SAME16      = 8'h93;
    localparam logic [7:0]  OP_VARLEN      = 8'h7f;
    localparam logic [7:0]  ADD_LEN_32     = 8'h18;
    localparam logic [15:0] SA_SAME32      = 16'h000d;
    localparam logic [2:0]  PTYPE_TYPE2    = 3'h1;
    localparam int          CDB_BYTES      = 32;

    // ******************************************************
    // Completion codes
    // ******************************************************
    localparam logic [7:0]  ST_GOOD        = 8'h00;
    localparam logic [7:0]  ST_CHECK       = 8'h02;
    localparam logic [3:0]  SK_NONE        = 4'h0;
    localparam logic [3:0]  SK_MEDIUM      = 4'h3;
    localparam logic [3:0]  SK_ILLEGAL     = 4'h5;
    localparam logic [7:0]  ASC_NONE       = 8'h00;
    localparam logic [7:0]  ASC_BAD_FIELD  = 8'h24;
    localparam logic [7:0]  ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0]  ASC_REF_TAG    = 8'h10;
    localparam logic [7:0]  ASC_MARKED_BAD = 8'h11;

    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [63:0] LBA_RST        = 64'h0;
    localparam logic [31:0] CNT_RST        = 32'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHK   = 3'b001,
        ST_DATA  = 3'b010,
        ST_WRITE = 3'b011,
        ST_DONE  = 3'b100
    } state_e;

    typedef enum logic [1:0] {
        CMD_NONE   = 2'b00,
        CMD_LONG16 = 2'b01,
        CMD_SAME   = 2'b10,
        CMD_SAME32 = 2'b11
    } cmd_e;

    typedef struct packed {
        logic [63:0] lba;
        logic        correction_disable_bit;
        logic        uncor;
        logic        pi_present;
        logic        pi_ref_check;
        logic [31:0] ref_tag;
        logic [15:0] app_tag;
        logic [15:0] app_mask;
    } media_wr_s;

    typedef struct packed {
        logic [7:0]  status;
        logic [3:0]  sense_key;
        logic [7:0]  asc;
        logic        ili;
        logic [31:0] info;
    } completion_s;

    localparam completion_s CPL_RST = '{ST_GOOD, SK_NONE, ASC_NONE,
                                        1'b0, 32'h0};

endpackage : wls_pkg

// ==== dv/wls_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module wls_assertions
    import wls_pkg::*;
(
    input wire logic                   clk_sys_i,
    input wire logic                   reset_n_i,
    input wire logic                   cdb_valid_i,
    input wire logic [8*CDB_BYTES-1:0] cdb_i,
    input wire logic [15:0]            data_len_i,
    input wire logic                   data_valid_i,
    input wire logic                   protection_enabled_flag_i,
    input wire logic [2:0]             prot_type_i,
    input wire logic                   application_tag_owner_i,
    input wire logic [63:0]            last_lba_i,
    input wire logic [31:0]            first_ref_tag_i,
    input wire logic                   media_ready_i,
    input wire logic                   cdb_ready_o,
    input wire logic                   data_ready_o,
    input wire logic                   media_wr_o,
    input wire media_wr_s              media_req_o,
    input wire logic                   cache_drop_o,
    input wire logic                   done_o,
    input wire completion_s            cpl_o
);
    // ****************************************
    // Properties
    // ****************************************
    logic take;
    assign take = cdb_ready_o && cdb_valid_i;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence accept_s;
        media_wr_o && media_ready_i;
    endsequence
    sequence err_s(logic [7:0] code);
        ##2 done_o && cpl_o.status == ST_CHECK && cpl_o.asc == code;
    endsequence
    chk_lba_step: assert property (accept_s ##1 media_wr_o |->
        media_req_o.lba == $past(media_req_o.lba) + 64'h1)
        else $error("lba did not advance by one");
    chk_req_hold: assert property (media_wr_o && !media_ready_i |=>
        media_wr_o && $stable(media_req_o)) else $error("request moved");
    chk_type2_gate: assert property (take && cdb_i[255:248] == OP_VARLEN
        && !(protection_enabled_flag_i && prot_type_i == PTYPE_TYPE2)
        |-> err_s(ASC_BAD_OPCODE)) else $error("type gate missed");
    chk_len_mismatch: assert property (take && cdb_i[255:248] == OP_LONG16
        && cdb_i[159:144] != 16'h0 && cdb_i[159:144] != data_len_i
        |-> err_s(ASC_BAD_FIELD) and ##2 cpl_o.ili) else $error("len check");
    chk_bad_opcode: assert property (take && cdb_i[255:248] == 8'h00
        |-> err_s(ASC_BAD_OPCODE)) else $error("unknown opcode");
    chk_drop_done: assert property (cache_drop_o |-> ##[1:3] done_o)
        else $error("no done after drop");
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_cor_wins: assert property (media_wr_o && media_req_o.correction_disable_bit
        |-> !media_req_o.uncor) else $error("uncor with correction_disable_bit");
    chk_idle_quiet: assert property (cdb_ready_o |-> !media_wr_o && !data_ready_o)
        else $error("activity while idle");
endmodule : wls_assertions
bind write_long_same_cdb_decoder wls_assertions wls_assertions_i (
    .clk_sys_i, .reset_n_i, .cdb_valid_i, .cdb_i, .data_len_i, .data_valid_i,
    .protection_enabled_flag_i, .prot_type_i, .application_tag_owner_i,
    .last_lba_i, .first_ref_tag_i, .media_ready_i, .cdb_ready_o,
    .data_ready_o, .media_wr_o, .media_req_o, .cache_drop_o, .done_o, .cpl_o);
`default_nettype wire

// ==== dv/initiator_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module initiator_model (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic data_req_i,
    input  wire logic wr_req_i,
    input  wire logic slow_i,
    output logic      data_valid_o,
    output logic      wr_ready_o
);
    // ****************************************
    // One data block, media acceptance
    // ****************************************
    always_ff @(negedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_valid_o <= 1'b0;
            wr_ready_o   <= 1'b0;
        end else begin
            if (data_req_i)
                data_valid_o <= 1'b1;
            else if (wr_req_i)
                data_valid_o <= 1'b0;
            // Slow mode drops ready every other cycle
            wr_ready_o <= wr_req_i && !(slow_i && wr_ready_o);
        end
    end
endmodule : initiator_model
`default_nettype wire

// ==== dv/write_long_same_cdb_decoder_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module write_long_same_cdb_decoder_tb;
    import wls_pkg::*;
    logic clk_sys_i, reset_n_i, cdb_valid_i, data_valid_i, media_ready_i;
    logic [255:0] cdb_i, cdb;
    logic [15:0]  data_len_i;
    logic [2:0]   prot_type_i;
    logic [63:0]  last_lba_i, lba_last;
    logic [31:0]  first_ref_tag_i;
    logic protection_enabled_flag_i, application_tag_owner_i, slow, got;
    logic cdb_ready_o, data_ready_o, media_wr_o, cache_drop_o, done_o;
    media_wr_s    media_req_o, req0;
    completion_s  cpl_o, cpl;
    int           fails, compares, nwr, drops;
    write_long_same_cdb_decoder write_long_same_cdb_decoder_i (.clk_sys_i,
        .reset_n_i, .cdb_valid_i, .cdb_i, .data_len_i, .data_valid_i,
        .protection_enabled_flag_i, .prot_type_i, .application_tag_owner_i,
        .last_lba_i, .first_ref_tag_i, .media_ready_i, .cdb_ready_o,
        .data_ready_o, .media_wr_o, .media_req_o, .cache_drop_o, .done_o,
        .cpl_o);
    initiator_model initiator_model_i (.clk_sys_i, .reset_n_i,
        .data_req_i(data_ready_o), .wr_req_i(media_wr_o), .slow_i(slow),
        .data_valid_o(data_valid_i), .wr_ready_o(media_ready_i));
    always #5 clk_sys_i = ~clk_sys_i;
    // ****************************************
    // Monitor and helpers
    // ****************************************
    always @(posedge clk_sys_i) begin
        if (media_wr_o && media_ready_i) begin
            if (nwr == 0) req0 = media_req_o;
            lba_last = media_req_o.lba;
            nwr++;
        end
        if (cache_drop_o) drops++;
        if (done_o) begin cpl = cpl_o; got = 1'b1; end
    end
    function automatic void put(int n, int nb, logic [63:0] v);
        for (int i = 0; i < nb; i++) cdb[8*(31-n-i)+:8] = v[8*(nb-1-i)+:8];
    endfunction : put
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    task final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // Reserved bytes stay zero unless a test sets them
    task run(input logic [15:0] dl);
        @(negedge clk_sys_i);
        nwr = 0; drops = 0; got = 1'b0;
        data_len_i = dl; cdb_i = cdb; cdb_valid_i = 1'b1;
        @(negedge clk_sys_i);
        cdb_valid_i = 1'b0;
        for (int i = 0; i < 400 && !got; i++) @(negedge clk_sys_i);
        if (!got) begin fails++; final_report(); end
        cdb = '0;
    endtask : run
    task s32(input logic [63:0] rt);
        put(0, 1, OP_VARLEN); put(7, 1, ADD_LEN_32); put(8, 2, SA_SAME32);
        put(12, 8, 64'h40); put(20, 4, rt); put(24, 2, 64'h1234);
        put(26, 2, 64'h00ff); put(28, 4, 64'h2); run(16'h0200);
    endtask : s32
    // ****************************************
    // Scenarios
    // ****************************************
    task test_same;
        put(0, 1, OP_SAME10); put(2, 4, 64'h5); put(7, 2, 64'h3);
        run(16'h0200);
        chk(nwr == 3 && req0.lba === 64'h5 && lba_last === 64'h7, "s10");
        chk(drops == 1 && cpl.status === ST_GOOD, "s10 end");
        slow = 1'b1;
        put(0, 1, OP_SAME16); put(2, 8, 64'h3d); run(16'h0200);
        chk(nwr == 3 && lba_last === 64'h3f, "zero count");
        slow = 1'b0;
        $display("test_same done");
    endtask : test_same
    task test_long;
        put(0, 1, OP_LONG16); put(1, 1, 64'h91); put(2, 8, 64'h20);
        put(12, 2, 64'h200); run(16'h0200);
        chk(nwr == 1 && req0.lba === 64'h20 && req0.correction_disable_bit === 1'b1
            && req0.uncor === 1'b0, "long16 write");
        put(0, 1, OP_LONG16); put(1, 1, 64'h51); put(12, 2, 64'h210);
        run(16'h0200);
        chk(nwr == 0 && cpl.sense_key === SK_ILLEGAL && cpl.ili === 1'b1
            && cpl.asc === ASC_BAD_FIELD && cpl.info === 32'h10, "len");
        $display("test_long done");
    endtask : test_long
    task test_same32;
        application_tag_owner_i = 1'b1;
        s32(64'h40);
        chk(nwr == 2 && cpl.status === ST_GOOD && req0.pi_present === 1'b1
            && req0.app_mask === 16'h00ff && req0.ref_tag === 32'h40, "32");
        chk(req0.app_tag === 16'h1234 &&
            req0.pi_ref_check === 1'b1, "tags");
        application_tag_owner_i = 1'b0;
        s32(64'h40);
        chk(req0.app_mask === 16'h0 &&
            req0.app_tag === 16'h0, "owner clear");
        s32(64'h41);
        chk(nwr == 1 && drops == 1 && cpl.asc === ASC_REF_TAG, "ref tag");
        prot_type_i = 3'h2;
        s32(64'h40);
        chk(nwr == 0 && cpl.asc === ASC_BAD_OPCODE, "type gate");
        prot_type_i = PTYPE_TYPE2;
        $display("test_same32 done");
    endtask : test_same32
    task test_reject;
        put(0, 1, OP_SAME10); put(6, 1, 64'h1); run(16'h0200);
        chk(nwr == 0 && cpl.asc === ASC_BAD_FIELD, "reserved");
        put(0, 1, 64'h0); run(16'h0200);
        chk(cpl.status === ST_CHECK && cpl.asc === ASC_BAD_OPCODE, "opcode");
        $display("test_reject done");
    endtask : test_reject
    initial begin
        clk_sys_i = 1'b0; reset_n_i = 1'b0; cdb_valid_i = 1'b0; slow = 1'b0;
        cdb_i = '0; cdb = '0; data_len_i = '0; got = 1'b0;
        protection_enabled_flag_i = 1'b1; prot_type_i = PTYPE_TYPE2;
        application_tag_owner_i = 1'b0; last_lba_i = 64'h3f;
        first_ref_tag_i = 32'h40; fails = 0; compares = 0;
        repeat (20) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        test_same();
        test_long();
        test_same32();
        test_reject();
        final_report();
    end
endmodule : write_long_same_cdb_decoder_tb
`default_nettype wire
